// File: src/clock_mode_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef CLOCK_MODE_MAP_SVH
`define CLOCK_MODE_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SYS_CLOCK_CTRL_OFS  8'h00
`define FAST_RC_CTRL_OFS    8'h04
`define FAST_XTAL_CTRL_OFS  8'h08
`define SLOW_XTAL_CTRL_OFS  8'h0C
`define MODE_STATUS_OFS     8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define SYSCLK_SELECT_MSB   7
`define SYSCLK_SELECT_LSB   5
`define HIGH_SRC_SELECT_BIT 3
`define LOW_SRC_SELECT_BIT  2
`define HIGH_KEEP_BIT       1
`define LOW_KEEP_BIT        0
`define FAST_FREQ_MSB       3
`define FAST_FREQ_LSB       2
`define STABLE_BIT          1
`define ENABLE_BIT          0
`define RANGE_BIT           2
`define SPEEDUP_BIT         2
`define BUSY_BIT            3

// ****************************************************************
// reset values and codes
// ****************************************************************
`define SYSCLK_SELECT_RST   3'h0
`define SYSCLK_LOW_CODE     3'h7
`define FAST_FREQ_RST       2'h0
`define FAST_RC_EN_RST      1'h1

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS       50
`define SETTLE_NS           1000
`define SETTLE_CYC          ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWITCH_NS           200
`define SWITCH_CYC          ((`SWITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: src/clock_mode_pkg.sv
// types shared by the clock and operating mode controller
package clock_mode_pkg;

    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_IDLE_LOW_ONLY,
        MODE_IDLE_BOTH_CLOCKS,
        MODE_IDLE_HIGH_ONLY
    } mode_type;

    typedef enum logic [2:0] {
        REG_SYS,
        REG_FAST_RC,
        REG_FAST_XTAL,
        REG_SLOW_XTAL,
        REG_STATUS,
        REG_NONE
    } reg_sel_type;

    // oscillator settle tracking
    typedef struct packed {
        logic       stable;
        logic [4:0] cnt;
    } settle_type;

    typedef struct packed {
        logic [2:0] sel;
        logic       high_src;
        logic       low_src;
        logic       high_keep;
        logic       low_keep;
        logic [1:0] rc_freq;
        logic       rc_en;
        settle_type rc;
        logic       xt_range;
        logic       xt_en;
        settle_type xt;
        logic       sx_en;
        settle_type sx;
        logic [2:0] rdy_s1;
        logic [2:0] rdy_s2;
        mode_type   mode;
        logic [2:0] sel_app;
        logic       high_app;
        logic       low_app;
        logic [2:0] sw_cnt;
        logic       busy;
        logic [1:0] rc_freq_app;
        logic       cpu_run;
        logic       high_on;
        logic       low_on;
        logic       sys_on;
        logic       rc_run;
        logic       xt_run;
        logic       lrc_run;
        logic       sx_run;
        logic       pready;
        logic       pslverr;
        logic [7:0] rdata;
    } state_type;

endpackage

// File: src/clock_mode_ctrl.sv
// system clock select and operating mode controller with apb registers
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "clock_mode_map.svh"

module clock_mode_ctrl
    import clock_mode_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    input  wire logic        watchdog_en,
    input  wire logic        crystal_pins_en,
    input  wire logic        fast_rc_ready,
    input  wire logic        fast_xtal_ready,
    input  wire logic        slow_xtal_ready,
    output logic             cpu_run,
    output logic             high_clk_on,
    output logic             low_clk_on,
    output logic             sysclk_on,
    output logic      [2:0]  sysclk_div_sel,
    output logic             high_src_applied,
    output logic             low_src_applied,
    output logic             clk_switch_busy,
    output logic             fast_rc_run,
    output logic      [1:0]  fast_rc_freq,
    output logic             fast_xtal_run,
    output logic             fast_xtal_range,
    output logic             slow_rc_run,
    output logic             slow_xtal_run
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic reg_sel_type decode(input logic [7:0] addr);
        reg_sel_type r;
        r = REG_NONE;
        case (addr)
            `SYS_CLOCK_CTRL_OFS: r = REG_SYS;
            `FAST_RC_CTRL_OFS:   r = REG_FAST_RC;
            `FAST_XTAL_CTRL_OFS: r = REG_FAST_XTAL;
            `SLOW_XTAL_CTRL_OFS: r = REG_SLOW_XTAL;
            `MODE_STATUS_OFS:    r = REG_STATUS;
            default:             r = REG_NONE;
        endcase
        return r;
    endfunction

    // restart on enable, hold low while off, then wait for ready
    function automatic settle_type settle(input logic       start,
                                          input logic       en,
                                          input settle_type cur,
                                          input logic       rdy);
        settle_type n;
        n = cur;
        if (start || !en) begin
            n.stable = 1'b0;
            n.cnt    = 5'(`SETTLE_CYC);
        end else if (cur.cnt != 5'h00) begin
            n.cnt = cur.cnt - 5'h01;
        end else begin
            n.stable = rdy;
        end
        return n;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    state_type   q;
    state_type   d;
    reg_sel_type rsel;
    reg_sel_type wsel;
    logic        wr;
    logic        rc_start;
    logic        xt_start;
    logic        sx_start;
    logic        sel_chg;

    always_comb begin
        d        = q;
        rc_start = 1'b0;
        xt_start = 1'b0;
        sx_start = 1'b0;
        sel_chg  = 1'b0;
        wr       = psel && penable && q.pready && pwrite;
        rsel     = decode(paddr);
        wsel     = decode(paddr);
        d.rdy_s1 = {slow_xtal_ready, fast_xtal_ready, fast_rc_ready};
        d.rdy_s2 = q.rdy_s1;

        // apb: answer prepared in setup, pready high in access
        d.pready  = psel && !penable;
        d.pslverr = 1'b0;
        d.rdata   = 8'h00;
        if (psel && !penable) begin
            d.pslverr = (rsel == REG_NONE);
            case (rsel)
                REG_SYS: begin
                    d.rdata = {q.sel, 1'b0, q.high_src, q.low_src,
                               q.high_keep, q.low_keep};
                end
                REG_FAST_RC: begin
                    d.rdata = {4'h0, q.rc_freq, q.rc.stable, q.rc_en};
                end
                REG_FAST_XTAL: begin
                    d.rdata = {5'h00, q.xt_range, q.xt.stable, q.xt_en};
                end
                REG_SLOW_XTAL: begin
                    d.rdata = {5'h00, 1'b1, q.sx.stable, q.sx_en};
                end
                REG_STATUS: begin
                    d.rdata = {4'h0, q.sw_cnt != 3'h0, q.mode};
                end
                default: d.rdata = 8'h00;
            endcase
        end

        // ************************************************************
        // register writes
        // ************************************************************
        if (wr) begin
            case (wsel)
                REG_SYS: begin
                    sel_chg = (pwdata[`SYSCLK_SELECT_MSB:`SYSCLK_SELECT_LSB]
                               != q.sel)
                           || (pwdata[`HIGH_SRC_SELECT_BIT] != q.high_src)
                           || (pwdata[`LOW_SRC_SELECT_BIT] != q.low_src);
                    d.sel = pwdata[`SYSCLK_SELECT_MSB:`SYSCLK_SELECT_LSB];
                    d.high_src  = pwdata[`HIGH_SRC_SELECT_BIT];
                    d.low_src   = pwdata[`LOW_SRC_SELECT_BIT];
                    d.high_keep = pwdata[`HIGH_KEEP_BIT];
                    d.low_keep  = pwdata[`LOW_KEEP_BIT];
                end
                REG_FAST_RC: begin
                    d.rc_freq = pwdata[`FAST_FREQ_MSB:`FAST_FREQ_LSB];
                    d.rc_en   = pwdata[`ENABLE_BIT];
                    rc_start  = pwdata[`ENABLE_BIT] && (!q.rc_en
                        || pwdata[`FAST_FREQ_MSB:`FAST_FREQ_LSB]
                           != q.rc_freq);
                end
                REG_FAST_XTAL: begin
                    if (!(crystal_pins_en && q.xt_en)) begin
                        d.xt_range = pwdata[`RANGE_BIT];
                    end
                    d.xt_en  = pwdata[`ENABLE_BIT];
                    xt_start = pwdata[`ENABLE_BIT] && !q.xt_en;
                end
                REG_SLOW_XTAL: begin
                    d.sx_en  = pwdata[`ENABLE_BIT];
                    sx_start = pwdata[`ENABLE_BIT] && !q.sx_en;
                end
                default: begin
                end
            endcase
        end

        // ************************************************************
        // oscillator stable flags
        // ************************************************************
        d.rc = settle(rc_start, d.rc_en, q.rc, q.rdy_s2[0]);
        d.xt = settle(xt_start, d.xt_en, q.xt, q.rdy_s2[1]);
        d.sx = settle(sx_start, d.sx_en, q.sx, q.rdy_s2[2]);
        if (d.rc.stable && !q.rc.stable) begin
            d.rc_freq_app = q.rc_freq;
        end

        // ************************************************************
        // clock switching delay
        // ************************************************************
        if (sel_chg) begin
            d.sw_cnt = 3'(`SWITCH_CYC);
        end else if (q.sw_cnt != 3'h0) begin
            d.sw_cnt = q.sw_cnt - 3'h1;
            if (q.sw_cnt == 3'h1) begin
                d.sel_app  = q.sel;
                d.high_app = q.high_src;
                d.low_app  = q.low_src;
            end
        end
        d.busy = (d.sw_cnt != 3'h0);

        // ************************************************************
        // operating mode
        // ************************************************************
        case (q.mode)
            MODE_RUN: begin
                if (halt_req) begin
                    case ({q.high_keep, q.low_keep})
                        2'b00:   d.mode = MODE_SLEEP;
                        2'b01:   d.mode = MODE_IDLE_LOW_ONLY;
                        2'b11:   d.mode = MODE_IDLE_BOTH_CLOCKS;
                        default: d.mode = MODE_IDLE_HIGH_ONLY;
                    endcase
                end
            end
            MODE_SLEEP,
            MODE_IDLE_LOW_ONLY,
            MODE_IDLE_BOTH_CLOCKS,
            MODE_IDLE_HIGH_ONLY: begin
                if (wake_req) begin
                    d.mode = MODE_RUN;
                end
            end
            default: d.mode = MODE_RUN;
        endcase

        // ************************************************************
        // clock and oscillator gating outputs
        // ************************************************************
        d.cpu_run = (d.mode == MODE_RUN);
        case (d.mode)
            MODE_RUN: begin
                // fast: high clock on; slow: per source enable
                d.high_on = (d.sel_app != `SYSCLK_LOW_CODE)
                    || (d.high_app ? d.xt_en : d.rc_en);
                d.low_on  = 1'b1;
                d.sys_on  = 1'b1;
            end
            MODE_IDLE_LOW_ONLY: begin
                d.high_on = 1'b0;
                d.low_on  = 1'b1;
                d.sys_on  = (d.sel_app == `SYSCLK_LOW_CODE);
            end
            MODE_IDLE_BOTH_CLOCKS: begin
                d.high_on = 1'b1;
                d.low_on  = 1'b1;
                d.sys_on  = 1'b1;
            end
            MODE_IDLE_HIGH_ONLY: begin
                d.high_on = 1'b1;
                d.low_on  = 1'b0;
                d.sys_on  = (d.sel_app != `SYSCLK_LOW_CODE);
            end
            default: begin
                d.high_on = 1'b0;
                d.low_on  = 1'b0;
                d.sys_on  = 1'b0;
            end
        endcase
        d.rc_run  = d.rc_en && (d.cpu_run || d.high_keep);
        d.xt_run  = d.xt_en && (d.cpu_run || d.high_keep);
        d.sx_run  = d.sx_en && (d.cpu_run || d.low_keep);
        d.lrc_run = (d.mode != MODE_SLEEP) || watchdog_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q             <= '0;
            q.sel         <= `SYSCLK_SELECT_RST;
            q.sel_app     <= `SYSCLK_SELECT_RST;
            q.rc_freq     <= `FAST_FREQ_RST;
            q.rc_freq_app <= `FAST_FREQ_RST;
            q.rc_en       <= `FAST_RC_EN_RST;
            q.rc.cnt      <= 5'(`SETTLE_CYC);
            q.xt.cnt      <= 5'(`SETTLE_CYC);
            q.sx.cnt      <= 5'(`SETTLE_CYC);
            q.mode        <= MODE_RUN;
            q.cpu_run     <= 1'b1;
            q.high_on     <= 1'b1;
            q.low_on      <= 1'b1;
            q.sys_on      <= 1'b1;
            q.rc_run      <= 1'b1;
            q.lrc_run     <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata           = {24'h000000, q.rdata};
    assign pready           = q.pready;
    assign pslverr          = q.pslverr;
    assign cpu_run          = q.cpu_run;
    assign high_clk_on      = q.high_on;
    assign low_clk_on       = q.low_on;
    assign sysclk_on        = q.sys_on;
    assign sysclk_div_sel   = q.sel_app;
    assign high_src_applied = q.high_app;
    assign low_src_applied  = q.low_app;
    assign clk_switch_busy  = q.busy;
    assign fast_rc_run      = q.rc_run;
    assign fast_rc_freq     = q.rc_freq_app;
    assign fast_xtal_run    = q.xt_run;
    assign fast_xtal_range  = q.xt_range;
    assign slow_rc_run      = q.lrc_run;
    assign slow_xtal_run    = q.sx_run;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence halt_in_run;
        q.mode == MODE_RUN && halt_req;
    endsequence

    sequence sel_write;
        wr && wsel == REG_SYS && sel_chg;
    endsequence

    switch_delay_a: assert property (
        sel_write ##1 !(wr && wsel == REG_SYS && sel_chg) [*4]
        |-> ##1 sysclk_div_sel == q.sel && high_src_applied == q.high_src
            && low_src_applied == q.low_src)
        else $error("selection not applied after switch delay");

    sleep_entry_a: assert property (
        halt_in_run and (!q.high_keep && !q.low_keep)
        |=> !cpu_run && !low_clk_on && !sysclk_on)
        else $error("sleep did not stop cpu and low clock");

    idle_low_a: assert property (
        halt_in_run and (!q.high_keep && q.low_keep)
        |=> !high_clk_on && low_clk_on
            && sysclk_on == (sysclk_div_sel == `SYSCLK_LOW_CODE))
        else $error("idle_low_only clock gating wrong");

    idle_both_a: assert property (
        halt_in_run and (q.high_keep && q.low_keep)
        |=> !cpu_run && high_clk_on && low_clk_on && sysclk_on)
        else $error("idle_both_clocks clock gating wrong");

    idle_high_a: assert property (
        halt_in_run and (q.high_keep && !q.low_keep)
        |=> high_clk_on && !low_clk_on
            && sysclk_on == (sysclk_div_sel != `SYSCLK_LOW_CODE))
        else $error("idle_high_only clock gating wrong");

    sleep_internal_slow_rc_a: assert property (
        q.mode == MODE_SLEEP && !halt_req && !wake_req
        |=> slow_rc_run == $past(watchdog_en))
        else $error("slow rc gating in sleep wrong");

    rc_restart_a: assert property (
        wr && wsel == REG_FAST_RC && rc_start
        |=> !q.rc.stable [*8])
        else $error("fast rc stable flag not cleared on restart");

    freq_apply_a: assert property (
        !q.rc.stable ##1 !q.rc.stable |-> $stable(fast_rc_freq))
        else $error("fast rc frequency applied before stable");

    range_lock_a: assert property (
        wr && wsel == REG_FAST_XTAL && crystal_pins_en && q.xt_en
        |=> $stable(fast_xtal_range))
        else $error("crystal range changed while locked");

    xtal_restart_a: assert property (
        wr && wsel == REG_FAST_XTAL && xt_start
        |=> !q.xt.stable ##1 !q.xt.stable)
        else $error("fast crystal stable flag not cleared");

    slow_restart_a: assert property (
        wr && wsel == REG_SLOW_XTAL && sx_start |=> !q.sx.stable)
        else $error("slow crystal stable flag not cleared");

endmodule // clock_mode_ctrl

// File: testbench/testbench.sv
// self-checking bench for the clock and operating mode controller
`timescale 1ns/10ps
`include "clock_mode_map.svh"

module testbench
    import clock_mode_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, rd, d, e;
    logic [31:0] pwdata, prdata;
    logic        halt_req, wake_req, watchdog_en, crystal_pins_en, err;
    logic        fast_rc_ready, fast_xtal_ready, slow_xtal_ready;
    logic        cpu_run, high_clk_on, low_clk_on, sysclk_on;
    logic        clk_switch_busy, high_src_applied, low_src_applied;
    logic        fast_rc_run, fast_xtal_run, fast_xtal_range;
    logic        slow_rc_run, slow_xtal_run;
    logic [2:0]  sysclk_div_sel, sv;
    logic [1:0]  fast_rc_freq;
    int          fail_count, tests_run, seed, n;

    clock_mode_ctrl u_clock_mode_ctrl (.*);

    always #25 pclk = ~pclk;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [7:0] x, y);
        tests_run++;
        if (y !== x) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, x, y);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, x);
        apb(1'b0, a, 8'h00);
        chk(nm, x, rd);
    endtask

    // waits out a select change and checks what got applied
    task automatic switch_wait(input logic [7:0] v);
        n = 0;
        @(negedge pclk);
        while (clk_switch_busy === 1'b1 && n < 50) begin
            n++;
            @(negedge pclk);
        end
        chk("busy_len", 8'(`SWITCH_CYC), 8'(n));
        chk("applied", {3'h0, v[7:5], v[3:2]}, {3'h0, sysclk_div_sel,
            high_src_applied, low_src_applied});
    endtask

    task automatic pulse(input logic h);
        @(posedge pclk);
        if (h) halt_req <= 1'b1;
        else wake_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
    endtask

    // mode code in the upper nibble, cpu/high/low/sys gates below
    function automatic logic [7:0] mode_exp(logic [1:0] k, logic [2:0] s);
        case (k)
            2'b00: mode_exp = 8'h10;
            2'b01: mode_exp = {4'h2, 3'b001, s == `SYSCLK_LOW_CODE};
            2'b10: mode_exp = {4'h4, 3'b010, s != `SYSCLK_LOW_CODE};
            default: mode_exp = 8'h37;
        endcase
    endfunction

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {pclk, presetn, psel, penable, pwrite, halt_req, wake_req} = 0;
        {watchdog_en, crystal_pins_en, paddr, pwdata} = 0;
        {fast_rc_ready, fast_xtal_ready, slow_xtal_ready} = 3'h7;
        {seed, fail_count, tests_run} = {32'd148, 64'd0};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("outs_rst", 8'hFA, {cpu_run, high_clk_on, low_clk_on, sysclk_on,
            fast_rc_run, fast_xtal_run, slow_rc_run, slow_xtal_run});
        for (int i = 0; i < 4; i++) begin
            rdchk("reg_rst", 8'(i * 4), 8'(32'h04000100 >> (i * 8)));
        end
        apb(1'b0, 8'h20, 8'h00);
        chk("unmapped", 8'h80, {err, rd[6:0]});
        for (int c = 1; c <= 8; c++) begin
            d = {c[2:0], 1'b1, 4'($random(seed))};
            apb(1'b1, `SYS_CLOCK_CTRL_OFS, d);
            switch_wait(d);
            rdchk("sys_rd", `SYS_CLOCK_CTRL_OFS, d & 8'hEF);
        end
        for (int c = 1; c <= 4; c++) begin
            d = {4'h0, c[1:0], 2'b01};
            apb(1'b1, `FAST_RC_CTRL_OFS, d);
            rdchk("rc_unstable", `FAST_RC_CTRL_OFS, d);
            chk("rc_hold", 8'(c - 1) & 8'h03, {6'h0, fast_rc_freq});
            repeat (30) @(posedge pclk);
            rdchk("rc_stable", `FAST_RC_CTRL_OFS, d | 8'h02);
            chk("rc_freq", {6'h0, c[1:0]}, {6'h0, fast_rc_freq});
        end
        apb(1'b1, `FAST_XTAL_CTRL_OFS, 8'h04);
        apb(1'b1, `FAST_XTAL_CTRL_OFS, 8'h05);
        rdchk("xt_unstable", `FAST_XTAL_CTRL_OFS, 8'h05);
        repeat (30) @(posedge pclk);
        rdchk("xt_stable", `FAST_XTAL_CTRL_OFS, 8'h07);
        chk("xt_run", 8'h03, {6'h0, fast_xtal_run, fast_xtal_range});
        crystal_pins_en <= 1'b1;
        apb(1'b1, `FAST_XTAL_CTRL_OFS, 8'h01);
        rdchk("xt_locked", `FAST_XTAL_CTRL_OFS, 8'h07);
        crystal_pins_en <= 1'b0;
        apb(1'b1, `FAST_XTAL_CTRL_OFS, 8'h00);
        rdchk("xt_off", `FAST_XTAL_CTRL_OFS, 8'h00);
        apb(1'b1, `SLOW_XTAL_CTRL_OFS, 8'h01);
        rdchk("sx_unstable", `SLOW_XTAL_CTRL_OFS, 8'h05);
        repeat (30) @(posedge pclk);
        rdchk("sx_stable", `SLOW_XTAL_CTRL_OFS, 8'h07);
        for (int s = 0; s < 2; s++) begin
            sv = (s == 0) ? 3'h7 : 3'h0;
            apb(1'b1, `SYS_CLOCK_CTRL_OFS, {sv, 5'h00});
            switch_wait({sv, 5'h00});
            for (int k = 0; k < 4; k++) begin
                watchdog_en <= 1'($random(seed));
                apb(1'b1, `SYS_CLOCK_CTRL_OFS, {sv, 3'h0, k[1:0]});
                pulse(1'b1);
                e = mode_exp(k[1:0], sv);
                chk("gates", {4'h0, e[3:0]}, {4'h0, cpu_run, high_clk_on,
                    low_clk_on, sysclk_on});
                chk("osc_runs", {5'h00, k[1], 1'b0, k[0]}, {5'h00,
                    fast_rc_run, fast_xtal_run, slow_xtal_run});
                if (k == 0) begin
                    chk("sleep_lrc", {7'h0, watchdog_en}, {7'h0, slow_rc_run});
                end
                rdchk("mode", `MODE_STATUS_OFS, {5'h00, e[6:4]});
                pulse(1'b0);
                chk("woken", 8'h03, {6'h00, cpu_run, high_clk_on});
            end
            if (s == 0) begin
                apb(1'b1, `FAST_RC_CTRL_OFS, 8'h00);
                @(negedge pclk);
                chk("slow_hi", 8'h00, {6'h0, high_clk_on, fast_rc_run});
                apb(1'b1, `FAST_RC_CTRL_OFS, 8'h01);
            end
        end
        conclude();
    end

    initial begin
        #1000000;
        fail_count++;
        conclude();
    end
endmodule // testbench
